//--- logic/pm_timer_params.svh
// offsets, field positions, reset values and counts of the pm timer block
// assumes inclusion by bare name from the design file only
`ifndef PM_TIMER_PARAMS_SVH
`define PM_TIMER_PARAMS_SVH

// ==========================================================================
// register locations
`define CFG_PM_ENABLE_FOUR   8'h83
`define CFG_GPT1_COUNT       8'h88
`define CFG_GPT1_CONTROL     8'h89
`define CFG_GPT2_COUNT       8'h8a
`define CFG_GPT2_CONTROL     8'h8b
`define CFG_GPT_ENABLE       8'h9a
`define CFG_GPT_STATUS       8'h9b
`define MEM_ACPI_COUNT       16'h001c
`define IO_ACPI_COUNT        16'h121c

// ==========================================================================
// reset values
`define ACPI_COUNT_RESET     24'hff_fffc
`define BYTE_RESET           8'h00

// ==========================================================================
// field positions
`define CTL2_SEC_DISK_RELOAD 7
`define CTL2_DISPLAY_BASE    6
`define CTL2_GPT2_WIDE       5
`define CTL2_GPT1_WIDE       4
`define CTL2_GPT2_BASE       3
`define CTL2_GPT2_PIN_RELOAD 2
`define CTL1_GPT1_BASE       7
`define EN4_ACPI_SMI         5
`define GPT_EN_FALLING       2
`define STS_ACPI             2
`define ACPI_MSB             23

// ==========================================================================
// timing counts, in slow timebase clocks and reference clocks
`define SLOW_TICKS_MS        32
`define SLOW_TICKS_SEC       32768
`define ACPI_REF_DIVIDE      4

`endif

//--- logic/pm_timer_pkg.sv
// types shared by the pm timer block
// assumes no other package is needed
`default_nettype none

package pm_timer_pkg;

  // ========================================================================
  // access space of the register port
  typedef enum logic [1:0] {
    SPACE_CFG = 2'b00,
    SPACE_MEM = 2'b01,
    SPACE_IO  = 2'b10
  } acc_space_t;

  // ========================================================================
  // general purpose timer states
  typedef enum logic [1:0] {
    TMR_IDLE = 2'b00,
    TMR_LOAD = 2'b01,
    TMR_RUN  = 2'b10
  } tmr_state_t;

endpackage

`default_nettype wire

//--- logic/pm_timer.sv
// pm general purpose timers, display-activity tick and acpi counter
// assumes all inputs synchronous to clock_i; slow and reference clocks
// arrive as sampled levels far slower than clock_i
`include "pm_timer_params.svh"
`default_nettype none

// Functional notes
// - secondary disk access reloads timer one when its retrigger bit set
// - display tick select: clear gives 1 ms, set gives 32 us
// - timer two width bit: clear 8-bit, count byte used directly
// - timer two 16-bit mode: count byte shifted left eight, low zeros
// - timer one width bit: clear 8-bit, count byte used directly
// - timer one 16-bit mode: count byte shifted left eight, low zeros
// - timer two timebase: clear one second, set one millisecond
// - configured reload pin edge reloads timer two when enabled
// - acpi counter steps at reference divided by four
// - acpi count read gives count in 23:0, zeros above
// - acpi count read-only, starts at 00fffffc after reset
// - acpi msb toggle raises management interrupt when enabled
// - acpi count readable at memory offset and at fixed io port
// - timers load on enable or reload, decrement per timebase tick
// - timer expiry sets its status flag and raises management interrupt
// - expired timer stays idle until re-enabled or count rewritten
// - pending load waits for the next tick of the selected timebase
module pm_timer
  import pm_timer_pkg::*;
(
  // clock and reset
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  // register access port
  input  wire logic [1:0]  acc_space_i,
  input  wire logic [15:0] acc_addr_i,
  input  wire logic        acc_wr_i,
  input  wire logic        acc_rd_i,
  input  wire logic [7:0]  acc_wdata_i,
  output var  logic [31:0] acc_rdata_o,
  output var  logic        acc_ack_o,
  // timebases and events
  input  wire logic        slow_timebase_clock_i,
  input  wire logic        acpi_ref_clock_i,
  input  wire logic        timer_reload_pin_i,
  input  wire logic        secondary_disk_access_i,
  // results
  output var  logic        system_mgmt_interrupt_o,
  output var  logic        display_timer_tick_o,
  output var  logic [1:0]  timer_expired_o
);

  // ========================================================================
  // register file
  logic [7:0]  enable_four, next_enable_four;
  logic [7:0]  count_byte [2];
  logic [7:0]  next_count_byte [2];
  logic [7:0]  control_one, next_control_one;
  logic [7:0]  control_two, next_control_two;
  logic [2:0]  gpt_enable, next_gpt_enable;
  logic [2:0]  status, next_status;
  logic [2:0]  status_set;
  logic [31:0] next_rdata;
  logic        next_ack;
  logic        cfg_wr;
  logic [23:0] acpi_count;
  logic [1:0]  count_written;

  always_comb begin
    cfg_wr           = acc_wr_i && (acc_space_i == SPACE_CFG);
    next_enable_four = enable_four;
    next_control_one = control_one;
    next_control_two = control_two;
    next_gpt_enable  = gpt_enable;
    next_count_byte  = count_byte;
    count_written    = 2'b00;
    next_status      = status | status_set;
    if (cfg_wr) begin
      case (acc_addr_i[7:0])
        `CFG_PM_ENABLE_FOUR: next_enable_four = acc_wdata_i;
        `CFG_GPT1_CONTROL:   next_control_one = acc_wdata_i;
        `CFG_GPT2_CONTROL:   next_control_two = acc_wdata_i;
        `CFG_GPT_ENABLE:     next_gpt_enable  = acc_wdata_i[2:0];
        `CFG_GPT1_COUNT: begin
          next_count_byte[0] = acc_wdata_i;
          count_written[0]   = 1'b1;
        end
        `CFG_GPT2_COUNT: begin
          next_count_byte[1] = acc_wdata_i;
          count_written[1]   = 1'b1;
        end
        // set wins over a same-cycle write-one clear
        `CFG_GPT_STATUS:
          next_status = (status & ~acc_wdata_i[2:0]) | status_set;
        default: next_status = status | status_set;
      endcase
    end
    next_rdata = 32'h0000_0000;
    if (acc_rd_i) begin
      case (acc_space_i)
        SPACE_CFG: begin
          case (acc_addr_i[7:0])
            `CFG_PM_ENABLE_FOUR: next_rdata[7:0] = enable_four;
            `CFG_GPT1_COUNT:     next_rdata[7:0] = count_byte[0];
            `CFG_GPT1_CONTROL:   next_rdata[7:0] = control_one;
            `CFG_GPT2_COUNT:     next_rdata[7:0] = count_byte[1];
            `CFG_GPT2_CONTROL:   next_rdata[7:0] = control_two;
            `CFG_GPT_ENABLE:     next_rdata[2:0] = gpt_enable;
            `CFG_GPT_STATUS:     next_rdata[2:0] = status;
            default:             next_rdata      = 32'h0000_0000;
          endcase
        end
        SPACE_MEM: if (acc_addr_i == `MEM_ACPI_COUNT) begin
          next_rdata = {8'h00, acpi_count};
        end
        SPACE_IO: if (acc_addr_i == `IO_ACPI_COUNT) begin
          next_rdata = {8'h00, acpi_count};
        end
        default: next_rdata = 32'h0000_0000;
      endcase
    end
    next_ack = acc_rd_i || acc_wr_i;
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      enable_four   <= `BYTE_RESET;
      control_one   <= `BYTE_RESET;
      control_two   <= `BYTE_RESET;
      gpt_enable    <= 3'b000;
      count_byte[0] <= `BYTE_RESET;
      count_byte[1] <= `BYTE_RESET;
      status        <= 3'b000;
      acc_rdata_o   <= 32'h0000_0000;
      acc_ack_o     <= 1'b0;
    end else begin
      enable_four   <= next_enable_four;
      control_one   <= next_control_one;
      control_two   <= next_control_two;
      gpt_enable    <= next_gpt_enable;
      count_byte    <= next_count_byte;
      status        <= next_status;
      acc_rdata_o   <= next_rdata;
      acc_ack_o     <= next_ack;
    end
  end

  // ========================================================================
  // timebase prescaler and acpi counter
  // no writes reach the acpi count: it is read-only by construction
  logic        slow_q, ref_q, pin_q;
  logic [14:0] prescale, next_prescale;
  logic [1:0]  ref_div, next_ref_div;
  logic [23:0] next_acpi_count;
  logic        slow_rise, ref_rise, acpi_step;
  logic        tick_ms, tick_sec, tick_short;
  logic        next_disp_tick, acpi_toggle;

  always_comb begin
    slow_rise     = slow_timebase_clock_i && !slow_q;
    ref_rise      = acpi_ref_clock_i && !ref_q;
    next_prescale = slow_rise ? prescale + 15'h0001 : prescale;
    tick_short    = slow_rise;
    tick_ms  = slow_rise && (prescale[4:0] == 5'(`SLOW_TICKS_MS - 1));
    tick_sec = slow_rise && (prescale == 15'(`SLOW_TICKS_SEC - 1));
    acpi_step     = ref_rise && (ref_div == 2'(`ACPI_REF_DIVIDE - 1));
    next_ref_div  = ref_rise ? ref_div + 2'h1 : ref_div;
    // wraps naturally past all ones
    next_acpi_count = acpi_step ? acpi_count + 24'h00_0001
                                : acpi_count;
    acpi_toggle = next_acpi_count[`ACPI_MSB] != acpi_count[`ACPI_MSB];
    // one slow clock is the nearest tick to 32 us
    next_disp_tick = control_two[`CTL2_DISPLAY_BASE] ? tick_short
                                                     : tick_ms;
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      slow_q               <= 1'b0;
      ref_q                <= 1'b0;
      pin_q                <= 1'b0;
      prescale             <= 15'h0000;
      ref_div              <= 2'h0;
      acpi_count           <= `ACPI_COUNT_RESET;
      display_timer_tick_o <= 1'b0;
    end else begin
      slow_q               <= slow_timebase_clock_i;
      ref_q                <= acpi_ref_clock_i;
      pin_q                <= timer_reload_pin_i;
      prescale             <= next_prescale;
      ref_div              <= next_ref_div;
      acpi_count           <= next_acpi_count;
      display_timer_tick_o <= next_disp_tick;
    end
  end

  // ========================================================================
  // general purpose timers
  tmr_state_t  tmr_state [2];
  tmr_state_t  next_tmr_state [2];
  logic [15:0] tmr_count [2];
  logic [15:0] next_tmr_count [2];
  logic [1:0]  en_q, wide, base_ms, reload, tick, expire;
  logic [15:0] load_value [2];
  logic        pin_edge;

  always_comb begin
    wide[0]    = control_two[`CTL2_GPT1_WIDE];
    wide[1]    = control_two[`CTL2_GPT2_WIDE];
    base_ms[0] = control_one[`CTL1_GPT1_BASE];
    base_ms[1] = control_two[`CTL2_GPT2_BASE];
    pin_edge   = gpt_enable[`GPT_EN_FALLING] ? (pin_q && !timer_reload_pin_i)
                                             : (!pin_q && timer_reload_pin_i);
    reload[0]  = control_two[`CTL2_SEC_DISK_RELOAD]
                 && secondary_disk_access_i;
    reload[1]  = control_two[`CTL2_GPT2_PIN_RELOAD] && pin_edge;
    // load waits for the selected prescaler wrap
    tick[0] = base_ms[0] ? tick_ms : tick_sec;
    tick[1] = base_ms[1] ? tick_ms : tick_sec;
    // wide mode: byte becomes the high half
    load_value[0] = wide[0] ? {count_byte[0], 8'h00}
                            : {8'h00, count_byte[0]};
    load_value[1] = wide[1] ? {count_byte[1], 8'h00}
                            : {8'h00, count_byte[1]};
    next_tmr_state = tmr_state;
    next_tmr_count = tmr_count;
    expire         = 2'b00;
    for (int i = 0; i < 2; i++) begin
      if (!gpt_enable[i]) begin
        next_tmr_state[i] = TMR_IDLE;
      end else if (!en_q[i] || count_written[i] ||
                   (reload[i] && tmr_state[i] != TMR_IDLE)) begin
        // an expired timer ignores reload events
        next_tmr_state[i] = TMR_LOAD;
      end else begin
        case (tmr_state[i])
          TMR_LOAD: if (tick[i]) begin
            next_tmr_count[i] = load_value[i];
            next_tmr_state[i] = TMR_RUN;
          end
          TMR_RUN: if (tick[i]) begin
            if (tmr_count[i] <= 16'h0001) begin
              next_tmr_count[i] = 16'h0000;
              next_tmr_state[i] = TMR_IDLE;
              expire[i]         = 1'b1;
            end else begin
              next_tmr_count[i] = tmr_count[i] - 16'h0001;
            end
          end
          TMR_IDLE: next_tmr_state[i] = TMR_IDLE;
          default:  next_tmr_state[i] = TMR_IDLE;
        endcase
      end
    end
    status_set = {acpi_toggle && enable_four[`EN4_ACPI_SMI],
                  expire};
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      en_q                    <= 2'b00;
      tmr_state[0]            <= TMR_IDLE;
      tmr_state[1]            <= TMR_IDLE;
      tmr_count[0]            <= 16'h0000;
      tmr_count[1]            <= 16'h0000;
      timer_expired_o         <= 2'b00;
      system_mgmt_interrupt_o <= 1'b0;
    end else begin
      en_q                    <= gpt_enable[1:0];
      tmr_state               <= next_tmr_state;
      tmr_count               <= next_tmr_count;
      timer_expired_o         <= expire;
      // level held while any status flag stands
      system_mgmt_interrupt_o <= |next_status;
    end
  end

endmodule

`default_nettype wire

//--- tb/pm_timer_sva.sv
// port relations of the pm timer block
// assumes binding onto pm_timer, one clock domain
`default_nettype none

module pm_timer_sva (
  // clock and reset
  input wire logic        clock_i,
  input wire logic        rst_n_i,
  // register access port
  input wire logic [1:0]  acc_space_i,
  input wire logic [15:0] acc_addr_i,
  input wire logic        acc_wr_i,
  input wire logic        acc_rd_i,
  input wire logic [7:0]  acc_wdata_i,
  input wire logic [31:0] acc_rdata_o,
  input wire logic        acc_ack_o,
  // results
  input wire logic        system_mgmt_interrupt_o,
  input wire logic        display_timer_tick_o,
  input wire logic [1:0]  timer_expired_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  // ==========================================
  // register port
  property p_ack; acc_rd_i || acc_wr_i |=> acc_ack_o; endproperty
  property p_quiet;
    !(acc_rd_i || acc_wr_i) |=> !acc_ack_o && acc_rdata_o == 32'h0000_0000;
  endproperty
  property p_top;
    acc_rd_i && acc_space_i != 2'b00 |=> acc_rdata_o[31:24] == 8'h00;
  endproperty
  a_ack: assert property (p_ack) else $error("missing ack");
  a_quiet: assert property (p_quiet) else $error("stray ack");
  a_top: assert property (p_top) else $error("upper byte set");

  // ==========================================
  // events; status clear needs a quiet cycle
  property p_exp_smi;
    |timer_expired_o |-> ##[1:2] system_mgmt_interrupt_o;
  endproperty
  property p_exp_once; |timer_expired_o |=> timer_expired_o == 2'b00;
  endproperty
  property p_disp_once; display_timer_tick_o |=> !display_timer_tick_o;
  endproperty
  property p_clear;
    acc_wr_i && acc_space_i == 2'b00 && acc_addr_i[7:0] == 8'h9b
      && acc_wdata_i == 8'h07 |-> ##2 !system_mgmt_interrupt_o;
  endproperty
  property p_hold;
    system_mgmt_interrupt_o && !acc_wr_i && !$past(acc_wr_i)
      |=> system_mgmt_interrupt_o;
  endproperty
  a_exp_smi: assert property (p_exp_smi) else $error("no irq");
  a_exp_once: assert property (p_exp_once) else $error("re-expiry");
  a_disp_once: assert property (p_disp_once) else $error("long tick");
  a_clear: assert property (p_clear) else $error("irq not cleared");
  a_hold: assert property (p_hold) else $error("irq dropped");
  c_exp_one: cover property (timer_expired_o[0]);
  c_exp_two: cover property (timer_expired_o[1]);
  c_irq: cover property ($rose(system_mgmt_interrupt_o));
endmodule

bind pm_timer pm_timer_sva u_pm_timer_sva (
  .clock_i                 (clock_i),
  .rst_n_i                 (rst_n_i),
  .acc_space_i             (acc_space_i),
  .acc_addr_i              (acc_addr_i),
  .acc_wr_i                (acc_wr_i),
  .acc_rd_i                (acc_rd_i),
  .acc_wdata_i             (acc_wdata_i),
  .acc_rdata_o             (acc_rdata_o),
  .acc_ack_o               (acc_ack_o),
  .system_mgmt_interrupt_o (system_mgmt_interrupt_o),
  .display_timer_tick_o    (display_timer_tick_o),
  .timer_expired_o         (timer_expired_o)
);

`default_nettype wire

//--- tb/pm_timer_tb_top.sv
// self-checking bench for the pm timer block
// assumes slow and reference levels are driven far below clock_i
`default_nettype none

module pm_timer_tb_top import pm_timer_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock_i = 0, rst_n_i = 0;
  logic [1:0]  acc_space_i = 0;
  logic [15:0] acc_addr_i = 0;
  logic        acc_wr_i = 0, acc_rd_i = 0;
  logic [7:0]  acc_wdata_i = 0;
  logic        slow_timebase_clock_i = 0, acpi_ref_clock_i = 0;
  logic        timer_reload_pin_i = 0, secondary_disk_access_i = 0;
  logic [31:0] acc_rdata_o, q;
  logic        acc_ack_o, system_mgmt_interrupt_o, display_timer_tick_o;
  logic [1:0]  timer_expired_o;
  int          miscompares = 0, samples_checked = 0, e, dt;

  pm_timer u_pm_timer (
    .clock_i                 (clock_i),
    .rst_n_i                 (rst_n_i),
    .acc_space_i             (acc_space_i),
    .acc_addr_i              (acc_addr_i),
    .acc_wr_i                (acc_wr_i),
    .acc_rd_i                (acc_rd_i),
    .acc_wdata_i             (acc_wdata_i),
    .acc_rdata_o             (acc_rdata_o),
    .acc_ack_o               (acc_ack_o),
    .slow_timebase_clock_i   (slow_timebase_clock_i),
    .acpi_ref_clock_i        (acpi_ref_clock_i),
    .timer_reload_pin_i      (timer_reload_pin_i),
    .secondary_disk_access_i (secondary_disk_access_i),
    .system_mgmt_interrupt_o (system_mgmt_interrupt_o),
    .display_timer_tick_o    (display_timer_tick_o),
    .timer_expired_o         (timer_expired_o)
  );
  always #2 clock_i = ~clock_i;

  // ==========================================
  // tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // answer stands one cycle, so it is taken at the following negedge
  task automatic xfer(input logic [1:0] sp, input logic [15:0] a,
                      input logic w, input logic [7:0] d);
    @(negedge clock_i);
    acc_space_i = sp;
    acc_addr_i = a;
    acc_wr_i = w;
    acc_rd_i = !w;
    acc_wdata_i = d;
    @(negedge clock_i);
    acc_wr_i = 0;
    acc_rd_i = 0;
    q = acc_rdata_o;
    chk({31'h0, acc_ack_o}, 32'h0000_0001);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(SPACE_CFG, {8'h00, a}, 1'b1, d);
  endtask
  task automatic rd(input logic [1:0] sp, input logic [15:0] a,
                    input logic [31:0] exp);
    xfer(sp, a, 1'b0, 8'h00);
    chk(q, exp);
  endtask
  task automatic ref_edges(input int n);
    repeat (n) begin
      @(negedge clock_i) acpi_ref_clock_i = 1;
      @(negedge clock_i) acpi_ref_clock_i = 0;
    end
  endtask
  // one-cycle reload event: the pin when p is set, else a disk access
  task automatic pulse(input logic p);
    @(negedge clock_i);
    timer_reload_pin_i = p;
    secondary_disk_access_i = !p;
    @(negedge clock_i);
    timer_reload_pin_i = 0;
    secondary_disk_access_i = 0;
  endtask
  // one spare period lets the last edge's pulses land
  task automatic slow(input int n, input int b, output int ex,
                      output int ticks);
    ex = 0;
    ticks = 0;
    for (int i = 1; i <= n + 1; i++) begin
      for (int k = 0; k < 4; k++) begin
        @(negedge clock_i);
        slow_timebase_clock_i = (k < 2) && (i <= n);
        if (timer_expired_o[b] === 1'b1 && ex == 0) ex = i;
        if (display_timer_tick_o === 1'b1) ticks++;
      end
    end
  endtask
  task automatic final_report;
    if (miscompares == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // ==========================================
  // sequence
  initial begin
    repeat (4) @(negedge clock_i);
    rst_n_i = 1;
    rd(SPACE_MEM, 16'h001c, 32'h00ff_fffc);
    rd(SPACE_IO, 16'h121c, 32'h00ff_fffc);
    xfer(SPACE_MEM, 16'h001c, 1'b1, 8'h55);
    rd(SPACE_MEM, 16'h001c, 32'h00ff_fffc);
    rd(SPACE_CFG, 16'h0083, 32'h0000_0000);
    wr(8'h83, 8'h20);
    ref_edges(3);
    rd(SPACE_MEM, 16'h001c, 32'h00ff_fffc);
    ref_edges(1);
    rd(SPACE_IO, 16'h121c, 32'h00ff_fffd);
    ref_edges(12);
    rd(SPACE_MEM, 16'h001c, 32'h0000_0000);
    rd(SPACE_CFG, 16'h009b, 32'h0000_0004);
    chk({31'h0, system_mgmt_interrupt_o}, 32'h0000_0001);
    wr(8'h9b, 8'h07);
    rd(SPACE_CFG, 16'h009b, 32'h0000_0000);
    chk({31'h0, system_mgmt_interrupt_o}, 32'h0000_0000);
    wr(8'h8b, 8'h00);
    slow(64, 0, e, dt);
    chk(dt, 32'h0000_0002);
    wr(8'h8b, 8'h40);
    rd(SPACE_CFG, 16'h008b, 32'h0000_0040);
    slow(8, 0, e, dt);
    chk(dt, 32'h0000_0008);
    wr(8'h8a, 8'h02);
    wr(8'h8b, 8'h08);
    wr(8'h9a, 8'h02);
    slow(100, 1, e, dt);
    chk({31'h0, e > 64 && e <= 96}, 32'h0000_0001);
    rd(SPACE_CFG, 16'h009b, 32'h0000_0002);
    // an expired timer two must ignore a pin edge
    wr(8'h8b, 8'h0c);
    pulse(1'b1);
    slow(100, 1, e, dt);
    chk(e, 32'h0000_0000);
    // a count rewrite restarts it; a pin edge mid-run reloads it
    wr(8'h8a, 8'h02);
    slow(40, 1, e, dt);
    chk(e, 32'h0000_0000);
    pulse(1'b1);
    slow(100, 1, e, dt);
    chk({31'h0, e > 64 && e <= 96}, 32'h0000_0001);
    // timer one 8-bit with disk reload, timer two on the one-second base
    wr(8'h9b, 8'h07);
    wr(8'h9a, 8'h00);
    wr(8'h88, 8'h02);
    wr(8'h8a, 8'h01);
    wr(8'h89, 8'h80);
    wr(8'h8b, 8'h80);
    wr(8'h9a, 8'h03);
    slow(40, 0, e, dt);
    chk(e, 32'h0000_0000);
    pulse(1'b0);
    slow(100, 0, e, dt);
    chk({31'h0, e > 64 && e <= 96}, 32'h0000_0001);
    rd(SPACE_CFG, 16'h009b, 32'h0000_0001);
    // both timers 16-bit on the millisecond base
    wr(8'h9b, 8'h07);
    wr(8'h9a, 8'h00);
    wr(8'h88, 8'h01);
    wr(8'h8a, 8'h01);
    wr(8'h89, 8'h80);
    wr(8'h8b, 8'h38);
    wr(8'h9a, 8'h03);
    slow(8100, 0, e, dt);
    chk(e, 32'h0000_0000);
    rd(SPACE_CFG, 16'h009b, 32'h0000_0000);
    slow(140, 0, e, dt);
    chk({31'h0, e > 92 && e <= 124}, 32'h0000_0001);
    rd(SPACE_CFG, 16'h009b, 32'h0000_0003);
    final_report();
  end
endmodule

`default_nettype wire
